// ==== cse_pkg.sv ====
package cse_pkg;
    localparam logic [7:0] CSE_OFS_THPD   = 8'h43;
    localparam logic [7:0] CSE_OFS_RATIO  = 8'h44;
    localparam logic [7:0] CSE_OFS_SELTMR = 8'h45;
    localparam logic [7:0] CSE_OFS_RESP   = 8'h46;
    localparam int         CSE_PD_LSB     = 4;
    localparam int         CSE_TH_LSB     = 0;
    localparam int         CSE_RATIO_LSB  = 0;
    localparam int         CSE_MODE_BIT   = 6;
    localparam int         CSE_TD_LSB     = 3;
    localparam int         CSE_SEL_LSB    = 0;
    localparam int         CSE_MAG_LSB    = 4;
    localparam int         CSE_RESP_LSB   = 0;
    localparam logic [3:0] CSE_RST_NIB    = 4'h0;
    localparam logic [2:0] CSE_RST_TRI    = 3'h0;
    localparam logic [1:0] CSE_RST_PD     = 2'h0;
    localparam int         CSE_CLK_HZ     = 40_000_000;
    localparam int         CSE_MS_TIME_US = 1000;
    localparam int         CSE_MS_CYCLES  = CSE_CLK_HZ / 1_000_000
                                            * CSE_MS_TIME_US;
    localparam logic [2:0] CSE_SEL_VRDY   = 3'h0;
    localparam logic [2:0] CSE_SEL_DP     = 3'h1;
    localparam logic [2:0] CSE_SEL_WIN    = 3'h2;
    localparam logic [2:0] CSE_SEL_DM     = 3'h3;
    localparam logic [2:0] CSE_SEL_DP2    = 3'h6;
    localparam logic [2:0] CSE_SEL_VPRS   = 3'h7;

    typedef enum logic [2:0] {
        CSE_IDLE    = 3'b000,
        CSE_DELAY   = 3'b001,
        CSE_HOLD    = 3'b010,
        CSE_APPLIED = 3'b011,
        CSE_DONE    = 3'b100
    } cse_state_t;

    function automatic logic [6:0] cse_td_ms(input logic [2:0] c);
        case (c)
            3'h0: cse_td_ms = 7'd0;
            3'h1: cse_td_ms = 7'd1;
            3'h2: cse_td_ms = 7'd5;
            3'h3: cse_td_ms = 7'd10;
            3'h4: cse_td_ms = 7'd20;
            3'h5: cse_td_ms = 7'd40;
            3'h6: cse_td_ms = 7'd80;
            default: cse_td_ms = 7'd100;
        endcase
    endfunction

    function automatic logic cse_resp_bad(input logic [3:0] c);
        cse_resp_bad = (c == 4'h5) || (c == 4'h8) || (c == 4'hb);
    endfunction

    function automatic logic cse_is_vbus(input logic [2:0] s);
        cse_is_vbus = (s == CSE_SEL_VRDY) || (s == CSE_SEL_VPRS);
    endfunction
endpackage

// ==== cse_decode.sv ====
module cse_decode
    import cse_pkg::*;
(
    input  wire logic [3:0]  th_code,
    input  wire logic [1:0]  pd_code,
    input  wire logic [2:0]  ratio_code,
    input  wire logic [3:0]  resp_code,
    input  wire logic [3:0]  mag_code,
    output logic      [11:0] th_mv,
    output logic      [7:0]  pd_ua,
    output logic      [6:0]  ratio_pct,
    output logic      [11:0] mag_val
);
    logic [11:0] volt_mv;
    logic [11:0] res_100r;
    logic [11:0] div_k;

    // Voltage steps shared by threshold and voltage magnitude
    function automatic logic [11:0] volt(input logic [3:0] c);
        case (c)
            4'h0: volt = 12'd0;
            4'h5: volt = 12'd500;
            4'h6: volt = 12'd600;
            4'h7: volt = 12'd700;
            4'h8: volt = 12'd800;
            4'h9: volt = 12'd900;
            4'ha: volt = 12'd1400;
            4'hb: volt = 12'd1600;
            4'hc: volt = 12'd1800;
            4'hd: volt = 12'd2000;
            4'he: volt = 12'd2200;
            4'hf: volt = 12'd0;
            default: volt = 12'd400;
        endcase
    endfunction

    assign th_mv = (th_code == 4'h3) ? 12'd300 :
                   (th_code == 4'h0) ? 12'd400 : volt(th_code);
    assign pd_ua = (pd_code == 2'h0) ? 8'd10 :
                   (pd_code == 2'h1) ? 8'd50 :
                   (pd_code == 2'h2) ? 8'd100 : 8'd150;
    assign ratio_pct = (ratio_code == 3'h0) ? 7'd25 :
                       (ratio_code == 3'h1) ? 7'd33 :
                       (ratio_code == 3'h2) ? 7'd40 :
                       (ratio_code == 3'h3) ? 7'd50 :
                       (ratio_code == 3'h4) ? 7'd54 :
                       (ratio_code == 3'h5) ? 7'd60 : 7'd66;
    assign volt_mv = volt(mag_code);

    always_comb begin
        case (mag_code)
            4'h0: res_100r = 12'd18;
            4'h1: res_100r = 12'd100;
            4'h2: res_100r = 12'd150;
            4'h3: res_100r = 12'd200;
            4'h4: res_100r = 12'd250;
            4'h5: res_100r = 12'd300;
            4'h6: res_100r = 12'd400;
            4'h7: res_100r = 12'd430;
            4'h8: res_100r = 12'd500;
            4'h9: res_100r = 12'd600;
            4'ha: res_100r = 12'd750;
            4'hb: res_100r = 12'd800;
            4'hc: res_100r = 12'd1000;
            4'hd: res_100r = 12'd1200;
            default: res_100r = 12'd1500;
        endcase
    end

    always_comb begin
        case (mag_code[1:0])
            2'h0: div_k = 12'd93;
            2'h1: div_k = 12'd100;
            2'h2: div_k = 12'd125;
            default: div_k = 12'd150;
        endcase
        if (mag_code[2] || (mag_code[3:2] == 2'h3)) begin
            div_k = 12'd200;
        end
    end

    assign mag_val = (resp_code <= 4'h3) ? volt_mv :
                     ((resp_code == 4'h6) || (resp_code == 4'h9) ||
                      (resp_code == 4'hc)) ? div_k : res_100r;
endmodule

// ==== cse_timer.sv ====
module cse_timer
    import cse_pkg::*;
#(
    parameter int MS_CYCLES = CSE_MS_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [6:0] dur_ms,
    output logic            expired
);
    logic [31:0] pre_r;
    logic [6:0]  ms_r;
    logic        run_r;
    logic        tick;

    // One-cycle millisecond enable from the divider
    assign tick = run_r && (pre_r == 32'(MS_CYCLES - 1));
    assign expired = run_r && (ms_r == 7'd0);

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_r <= 32'h0;
            ms_r  <= 7'h0;
            run_r <= 1'b0;
        end else if (start) begin
            pre_r <= 32'h0;
            ms_r  <= dur_ms;
            run_r <= 1'b1;
        end else if (expired) begin
            run_r <= 1'b0;
        end else if (run_r) begin
            pre_r <= tick ? 32'h0 : pre_r + 32'h1;
            if (tick) begin
                ms_r <= ms_r - 7'd1;
            end
        end
    end
endmodule

// ==== cse_charger_emul_cfg.sv ====
// The address-and-strobe port was chosen for this implementation.
module cse_charger_emul_cfg
    import cse_pkg::*;
#(
    parameter int MS_CYCLES = CSE_MS_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        profile_legacy,
    input  wire logic        profile_std,
    input  wire logic        run,
    input  wire logic        vbus_ready_in,
    input  wire logic        vbus_present_in,
    input  wire logic        dp_above_th_in,
    input  wire logic        dm_above_th_in,
    input  wire logic        dp_above_floor_in,
    output logic      [11:0] first_threshold_mv,
    output logic             cmp_th_enable,
    output logic      [7:0]  pulldown_ua,
    output logic             pulldown_en,
    output logic      [6:0]  ratio_pct,
    output logic             resp_active,
    output logic      [3:0]  resp_code,
    output logic      [11:0] resp_mag,
    output logic             resp_dp,
    output logic             resp_dm,
    output logic             reset_pd_keep,
    output logic             next_stim_ok
);
    logic [1:0]  first_pulldown_current_sel_r;
    logic [3:0]  first_threshold_sel_r;
    logic [2:0]  first_divider_ratio_r;
    logic        second_timer_mode_r;
    logic [2:0]  second_timer_duration_r;
    logic [2:0]  second_stimulus_select_r;
    logic [3:0]  second_response_magnitude_r;
    logic [3:0]  second_response_code_r;

    logic [4:0]  sync1_r;
    logic [4:0]  sync2_r;
    logic        vrdy;
    logic        vprs;
    logic        dp_hi;
    logic        dm_hi;
    logic        dp_floor;

    cse_state_t  state_r;
    cse_state_t  state_nxt;
    logic        timer_start;
    logic        timer_exp;
    logic        apply;
    logic        remove;
    logic        hit;

    logic        wr_thpd;
    logic        wr_ratio;
    logic        wr_seltmr;
    logic        wr_resp;
    logic [7:0]  rd_mux;
    logic [11:0] th_mv;
    logic [7:0]  pd_ua;
    logic [6:0]  ratio_val;
    logic [11:0] mag_val;
    logic        resp_is_volt;

    logic [7:0]  rdata_r;
    logic [11:0] th_mv_r;
    logic        cmp_en_r;
    logic [7:0]  pd_ua_r;
    logic        pd_en_r;
    logic [6:0]  ratio_r;
    logic        active_r;
    logic [3:0]  code_r;
    logic [11:0] mag_r;
    logic        dp_r;
    logic        dm_r;
    logic        pd_keep_r;
    logic        next_ok_r;

    // Comparator and bus-voltage flags arrive from the analog side
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 5'h0;
            sync2_r <= 5'h0;
        end else begin
            sync1_r <= {vbus_ready_in, vbus_present_in, dp_above_th_in,
                        dm_above_th_in, dp_above_floor_in};
            sync2_r <= sync1_r;
        end
    end

    assign vrdy     = sync2_r[4];
    assign vprs     = sync2_r[3];
    assign dp_hi    = sync2_r[2];
    assign dm_hi    = sync2_r[1];
    assign dp_floor = sync2_r[0];

    // Register access decode
    assign wr_thpd   = wr && (addr == CSE_OFS_THPD) &&
                       !profile_legacy;
    assign wr_ratio  = wr && (addr == CSE_OFS_RATIO) &&
                       !profile_std;
    assign wr_seltmr = wr && (addr == CSE_OFS_SELTMR);
    assign wr_resp   = wr && (addr == CSE_OFS_RESP);

    assign rd_mux =
        (addr == CSE_OFS_THPD) ?
            {2'h0, first_pulldown_current_sel_r, first_threshold_sel_r} :
        (addr == CSE_OFS_RATIO) ?
            {5'h0, first_divider_ratio_r} :
        (addr == CSE_OFS_SELTMR) ?
            {1'b0, second_timer_mode_r, second_timer_duration_r,
             second_stimulus_select_r} :
        (addr == CSE_OFS_RESP) ?
            {second_response_magnitude_r, second_response_code_r} :
        8'h00;

    // Each field is checked alone, so a bad code in one field
    // does not block a good code in the other
    always_ff @(posedge clk) begin
        if (rst) begin
            first_pulldown_current_sel_r <= CSE_RST_PD;
            first_threshold_sel_r        <= CSE_RST_NIB;
            first_divider_ratio_r        <= CSE_RST_TRI;
            second_timer_mode_r          <= 1'b0;
            second_timer_duration_r      <= CSE_RST_TRI;
            second_stimulus_select_r     <= CSE_RST_TRI;
            second_response_magnitude_r  <= CSE_RST_NIB;
            second_response_code_r       <= CSE_RST_NIB;
        end else begin
            if (wr_thpd) begin
                first_pulldown_current_sel_r <=
                    wdata[CSE_PD_LSB +: 2];
                if (wdata[CSE_TH_LSB +: 4] != 4'hf) begin
                    first_threshold_sel_r <=
                        wdata[CSE_TH_LSB +: 4];
                end
            end
            if (wr_ratio && (wdata[CSE_RATIO_LSB +: 3] != 3'h7)) begin
                first_divider_ratio_r <=
                    wdata[CSE_RATIO_LSB +: 3];
            end
            if (wr_seltmr) begin
                second_timer_mode_r     <= wdata[CSE_MODE_BIT];
                second_timer_duration_r <= wdata[CSE_TD_LSB +: 3];
                if (wdata[CSE_SEL_LSB + 2 -: 2] != 2'h2) begin
                    second_stimulus_select_r <=
                        wdata[CSE_SEL_LSB +: 3];
                end
            end
            if (wr_resp) begin
                if (wdata[CSE_MAG_LSB +: 4] != 4'hf) begin
                    second_response_magnitude_r <=
                        wdata[CSE_MAG_LSB +: 4];
                end
                if (!cse_resp_bad(wdata[CSE_RESP_LSB +: 4])) begin
                    second_response_code_r <=
                        wdata[CSE_RESP_LSB +: 4];
                end
            end
        end
    end

    cse_decode u_decode (
        .th_code    (first_threshold_sel_r),
        .pd_code    (first_pulldown_current_sel_r),
        .ratio_code (first_divider_ratio_r),
        .resp_code  (second_response_code_r),
        .mag_code   (second_response_magnitude_r),
        .th_mv      (th_mv),
        .pd_ua      (pd_ua),
        .ratio_pct  (ratio_val),
        .mag_val    (mag_val)
    );

    // Stimulus detection for the second stimulus
    assign hit =
        (second_stimulus_select_r == CSE_SEL_VRDY) ? vrdy :
        (second_stimulus_select_r == CSE_SEL_VPRS) ? vprs :
        (second_stimulus_select_r == CSE_SEL_DP)   ? dp_hi :
        (second_stimulus_select_r == CSE_SEL_DP2)  ? dp_hi :
        (second_stimulus_select_r == CSE_SEL_DM)   ? dm_hi :
        (second_stimulus_select_r == CSE_SEL_WIN)  ?
            (!dp_hi && dp_floor) : 1'b0;

    // Follows the applied response, so later field writes cannot
    // switch the pull-down current on or off behind it
    assign resp_is_volt = (code_r != 4'h0) && (code_r <= 4'h3);

    always_comb begin
        state_nxt   = state_r;
        timer_start = 1'b0;
        apply       = 1'b0;
        remove      = 1'b0;
        case (state_r)
            CSE_IDLE: begin
                if (run && hit) begin
                    timer_start = 1'b1;
                    if (second_timer_mode_r) begin
                        apply     = 1'b1;
                        state_nxt = CSE_HOLD;
                    end else begin
                        state_nxt = CSE_DELAY;
                    end
                end
            end
            CSE_DELAY: begin
                if (timer_exp) begin
                    apply     = 1'b1;
                    state_nxt = CSE_APPLIED;
                end
            end
            CSE_HOLD: begin
                if (timer_exp) begin
                    if (!hit) begin
                        remove    = 1'b1;
                        state_nxt = CSE_DONE;
                    end else begin
                        state_nxt = CSE_APPLIED;
                    end
                end
            end
            CSE_APPLIED: begin
                if (!hit) begin
                    remove    = second_timer_mode_r;
                    state_nxt = CSE_DONE;
                end
            end
            default: begin
                state_nxt = CSE_DONE;
            end
        endcase
        if (!run) begin
            state_nxt = CSE_IDLE;
        end
    end

    cse_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .clk     (clk),
        .rst     (rst),
        .start   (timer_start),
        .dur_ms  (cse_td_ms(second_timer_duration_r)),
        .expired (timer_exp)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= CSE_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Response drive; leaving the run drops everything back
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            active_r  <= 1'b0;
            code_r    <= 4'h0;
            mag_r     <= 12'h0;
            dp_r      <= 1'b0;
            dm_r      <= 1'b0;
            pd_keep_r <= 1'b1;
            next_ok_r <= 1'b0;
        end else begin
            if (apply) begin
                code_r   <= second_response_code_r;
                mag_r    <= mag_val;
                active_r <= (second_response_code_r != 4'h0) &&
                            (second_response_code_r[3:1] != 3'h7);
                dp_r <= (second_response_code_r == 4'h1) ||
                        (second_response_code_r == 4'h3) ||
                        (second_response_code_r == 4'h4) ||
                        (second_response_code_r == 4'h6) ||
                        (second_response_code_r == 4'ha) ||
                        (second_response_code_r == 4'hc) ||
                        (second_response_code_r == 4'hd);
                dm_r <= (second_response_code_r == 4'h2) ||
                        (second_response_code_r == 4'h3) ||
                        (second_response_code_r == 4'h7) ||
                        (second_response_code_r == 4'h9) ||
                        (second_response_code_r == 4'ha) ||
                        (second_response_code_r == 4'hc) ||
                        (second_response_code_r == 4'hd);
                if (second_response_code_r[3:1] == 3'h7) begin
                    if (second_stimulus_select_r == CSE_SEL_VPRS) begin
                        pd_keep_r <= 1'b0;
                    end
                end else if (second_response_code_r != 4'h0) begin
                    pd_keep_r <= 1'b0;
                end
            end else if (remove) begin
                active_r <= 1'b0;
                dp_r     <= 1'b0;
                dm_r     <= 1'b0;
            end
            // Bus-voltage stimuli never wait for their own removal
            if ((state_r == CSE_IDLE) && run && hit &&
                cse_is_vbus(second_stimulus_select_r)) begin
                next_ok_r <= 1'b1;
            end else if (state_nxt == CSE_DONE) begin
                next_ok_r <= 1'b1;
            end
        end
    end

    // Profile-gated views of the first stimulus settings, plus read data and enables
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r  <= 8'h00;
            th_mv_r  <= 12'h0;
            cmp_en_r <= 1'b0;
            pd_ua_r  <= 8'h0;
            pd_en_r  <= 1'b0;
            ratio_r  <= 7'h0;
        end else begin
            rdata_r  <= rd ? rd_mux : 8'h00;
            th_mv_r  <= profile_legacy ? 12'h0 : th_mv;
            cmp_en_r <= !cse_is_vbus(second_stimulus_select_r);
            pd_ua_r  <= profile_legacy ? 8'h0 : pd_ua;
            pd_en_r  <= run && !profile_legacy && active_r &&
                        resp_is_volt && (mag_r == 12'h0);
            ratio_r  <= profile_std ? 7'h0 : ratio_val;
        end
    end

    assign rdata              = rdata_r;
    assign first_threshold_mv = th_mv_r;
    assign cmp_th_enable      = cmp_en_r;
    assign pulldown_ua        = pd_ua_r;
    assign pulldown_en        = pd_en_r;
    assign ratio_pct          = ratio_r;
    assign resp_active        = active_r;
    assign resp_code          = code_r;
    assign resp_mag           = mag_r;
    assign resp_dp            = dp_r;
    assign resp_dm            = dm_r;
    assign reset_pd_keep      = pd_keep_r;
    assign next_stim_ok       = next_ok_r;
endmodule

// ==== cse_charger_emul_cfg_assertions.sv ====
module cse_charger_emul_cfg_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        profile_legacy,
    input wire logic        profile_std,
    input wire logic        run,
    input wire logic [11:0] first_threshold_mv,
    input wire logic [7:0]  pulldown_ua,
    input wire logic        pulldown_en,
    input wire logic [6:0]  ratio_pct,
    input wire logic        resp_active,
    input wire logic [3:0]  resp_code,
    input wire logic        resp_dp,
    input wire logic        resp_dm
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_one_rd;
        rd ##1 !rd;
    endsequence
    property p_rd_stands;
        s_one_rd |=> rdata == 8'h00;
    endproperty
    a_rd_stands: assert property (p_rd_stands)
        else $error("rdata held");
    property p_rd_quiet;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("rdata no read");
    property p_legacy_off;
        profile_legacy |=> first_threshold_mv == 12'h000 &&
                           pulldown_ua == 8'h00;
    endproperty
    a_legacy_off: assert property (p_legacy_off)
        else $error("legacy th");
    property p_std_off;
        profile_std |=> ratio_pct == 7'h00;
    endproperty
    a_std_off: assert property (p_std_off)
        else $error("std ratio");
    property p_pd_vals;
        pulldown_ua inside {8'h00, 8'h0a, 8'h32, 8'h64, 8'h96};
    endproperty
    a_pd_vals: assert property (p_pd_vals)
        else $error("pd value");
    property p_ratio_vals;
        ratio_pct inside {7'h00, 7'h19, 7'h21, 7'h28, 7'h32, 7'h36, 7'h3c,
                          7'h42};
    endproperty
    a_ratio_vals: assert property (p_ratio_vals)
        else $error("ratio");
    property p_th_vals;
        first_threshold_mv inside {12'h000, 12'h12c, 12'h190, 12'h1f4,
            12'h258, 12'h2bc, 12'h320, 12'h384, 12'h578, 12'h640, 12'h708,
            12'h7d0, 12'h898};
    endproperty
    a_th_vals: assert property (p_th_vals)
        else $error("threshold");
    property p_run_off;
        !run |=> !resp_active && !pulldown_en;
    endproperty
    a_run_off: assert property (p_run_off)
        else $error("run low");
    property p_resp_code;
        resp_active |-> !(resp_code inside {4'h0, 4'h5, 4'h8, 4'hb, 4'he,
                                            4'hf});
    endproperty
    a_resp_code: assert property (p_resp_code)
        else $error("code");
    property p_pd_en;
        pulldown_en |-> $past(resp_active) &&
                        $past(resp_code) inside {4'h1, 4'h2, 4'h3};
    endproperty
    a_pd_en: assert property (p_pd_en)
        else $error("pd enable");
    property p_dp_only;
        resp_active && resp_code == 4'h1 |-> resp_dp && !resp_dm;
    endproperty
    a_dp_only: assert property (p_dp_only)
        else $error("dp pin");
endmodule

bind cse_charger_emul_cfg cse_charger_emul_cfg_checker u_chk (.clk, .rst,
    .rd, .rdata, .profile_legacy, .profile_std, .run, .first_threshold_mv,
    .pulldown_ua, .pulldown_en, .ratio_pct, .resp_active, .resp_code,
    .resp_dp, .resp_dm);

// ==== cse_portable_model.sv ====
module cse_portable_model (
    input  wire logic       clk,
    input  wire logic [4:0] lvl,
    output logic            vbus_ready_in,
    output logic            vbus_present_in,
    output logic            dp_above_th_in,
    output logic            dm_above_th_in,
    output logic            dp_above_floor_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin levels settle a cycle after the device moves, like real loads
    always_ff @(posedge clk) begin
        {vbus_ready_in, vbus_present_in, dp_above_th_in, dm_above_th_in,
         dp_above_floor_in} <= lvl;
    end
endmodule

// ==== cse_charger_emul_cfg_tb.sv ====
module cse_charger_emul_cfg_tb;
    import cse_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr = 0, rd = 0, run = 0;
    logic profile_legacy = 0, profile_std = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, m[4];
    logic [4:0] lvl = 5'h00;
    logic vr, vp, dpt, dmt, dpf, cen, pen, ract, rdp, rdm, nok, pdk;
    logic [11:0] thr, rmag;
    logic [7:0] pd;
    logic [6:0] rat;
    logic [3:0] rcode;
    int errors = 0, checks_done = 0;
    int thtab[16] = '{400, 400, 400, 300, 400, 500, 600, 700, 800, 900,
                      1400, 1600, 1800, 2000, 2200, 0};
    int rtab[8] = '{25, 33, 40, 50, 54, 60, 66, 0};
    int pdtab[4] = '{10, 50, 100, 150};
    int dtab[16] = '{0, 2, 1, 3, 2, 0, 2, 1, 0, 1, 3, 0, 3, 3, 0, 0};
    always #12.5 clk = ~clk;
    cse_charger_emul_cfg #(.MS_CYCLES(4)) DUT (.clk(clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .profile_legacy(profile_legacy), .profile_std(profile_std),
        .run(run), .vbus_ready_in(vr), .vbus_present_in(vp),
        .dp_above_th_in(dpt), .dm_above_th_in(dmt), .dp_above_floor_in(dpf),
        .first_threshold_mv(thr), .cmp_th_enable(cen), .pulldown_ua(pd),
        .pulldown_en(pen), .ratio_pct(rat), .resp_active(ract),
        .resp_code(rcode), .resp_mag(rmag), .resp_dp(rdp), .resp_dm(rdm),
        .reset_pd_keep(pdk), .next_stim_ok(nok));
    cse_portable_model u_dev (.clk(clk), .lvl(lvl), .vbus_ready_in(vr),
        .vbus_present_in(vp), .dp_above_th_in(dpt), .dm_above_th_in(dmt),
        .dp_above_floor_in(dpf));
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string n, int e, logic [11:0] g);
        checks_done++;
        if (g !== 12'(e)) begin
            errors++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic wreg(logic [7:0] a, logic [7:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [7:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Forbidden codes leave only their own field untouched
    task automatic mwr(logic [7:0] a, logic [7:0] v);
        case (a)
            8'h43: if (!profile_legacy) m[0] = {2'b00, v[5:4],
                       v[3:0] == 4'hf ? m[0][3:0] : v[3:0]};
            8'h44: if (!profile_std && v[2:0] != 3'h7) m[1] = {5'h00, v[2:0]};
            8'h45: m[2] = {1'b0, v[6:3], v[2:1] == 2'b10 ? m[2][2:0] : v[2:0]};
            8'h46: m[3] = {v[7:4] == 4'hf ? m[3][7:4] : v[7:4],
                       v[3:0] inside {5, 8, 11} ? m[3][3:0] : v[3:0]};
            default: ;
        endcase
        wreg(a, v);
    endtask
    task automatic eng(logic [7:0] st, rs, logic [4:0] lv, int lo, hi, mg);
        int n;
        n = 0;
        mwr(8'h45, st);
        mwr(8'h46, rs);
        @(posedge clk);
        lvl <= lv; run <= 1'b1;
        #1;
        while (ract !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        chk("latency_lo", 1, n >= lo);
        chk("latency_hi", 1, n <= hi);
        chk("resp_code", rs[3:0], rcode);
        if (mg >= 0) chk("resp_mag", mg, rmag);
        chk("resp_dp", dtab[rs[3:0]] / 2, rdp);
        chk("resp_dm", dtab[rs[3:0]] % 2, rdm);
        chk("next_ok", st[2:0] inside {0, 7}, nok);
        chk("pd_keep", rs[3:1] == 3'h7 && st[2:0] != 3'h7, pdk);
        @(posedge clk);
        lvl <= 5'h00;
        #1 chk("pd_en", !rs[7:4] && rs[3:0] inside {[1:3]}, pen);
        repeat (30) @(posedge clk);
        #1 chk("held", !st[6], ract);
        @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        stop_test;
    end
    initial begin
        logic [7:0] a, v;
        int pr;
        m = '{default: 8'h00};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'h104e));
        for (int i = 0; i < 4; i++) begin
            rreg(8'(8'h43 + i));
            chk("reset", 0, d);
        end
        chk("pd_keep", 1, pdk);
        eng(8'h41, 8'h31, 5'h04, 1, 8, 400);
        eng(8'h0b, 8'h72, 5'h02, 4, 14, 700);
        eng(8'h40, 8'h0d, 5'h10, 1, 8, 18);
        eng(8'h52, 8'h0c, 5'h01, 1, 8, 93);
        eng(8'h1e, 8'h04, 5'h04, 40, 52, 18);
        eng(8'h47, 8'he2, 5'h08, 1, 8, 2200);
        eng(8'h49, 8'h03, 5'h04, 1, 8, -1);
        repeat (60) begin
            a = 8'h42 + 8'($urandom % 6);
            v = 8'($urandom);
            pr = $urandom % 3;
            @(posedge clk);
            profile_legacy <= pr == 1;
            profile_std <= pr == 2;
            #1 mwr(a, v);
            rreg(a);
            chk("rdata", a inside {[8'h43:8'h46]} ? m[a - 8'h43] : 0,
                d);
            chk("thr", profile_legacy ? 0 : thtab[m[0][3:0]],
                thr);
            chk("pd", profile_legacy ? 0 : pdtab[m[0][5:4]],
                pd);
            chk("ratio", profile_std ? 0 : rtab[m[1][2:0]],
                rat);
            chk("cmp_en", !(m[2][2:0] inside {0, 7}), cen);
        end
        stop_test;
    end
endmodule
